// ===== src/kwd_pkg.sv
package kwd_pkg;

	// Register placement: printed offset is an index, byte address is four times it
	localparam int KWD_AW = 12;
	localparam logic [KWD_AW-1:0] KWD_CTRL_IDX = 12'h0E6;
	localparam logic [KWD_AW-1:0] KWD_CTRL_ADDR = 12'h398;

	// Key words written to the control register
	localparam logic [15:0] KWD_KEY_CFG1 = 16'h3333;
	localparam logic [15:0] KWD_KEY_CFG2 = 16'hCCCC;
	localparam logic [15:0] KWD_KEY_RD1 = 16'h5555;
	localparam logic [15:0] KWD_KEY_RD2 = 16'hAAAA;

	// Field positions of the control word
	localparam int KWD_ON_BIT = 15;
	localparam int KWD_RSTON_BIT = 14;
	localparam int KWD_RSTSEEN_BIT = 13;
	localparam int KWD_INTSEEN_BIT = 12;
	localparam int KWD_TMO_LSB = 0;
	localparam int KWD_TMO_W = 8;

	// Exponent figures and counter width
	localparam int KWD_EXP_LO = 10;
	localparam int KWD_EXP_HI = 20;
	localparam int KWD_CNT_W = 27;

	// Reset value of the control word: running, interrupt first, longest interval
	localparam logic [15:0] KWD_CTRL_RST = 16'h8080;

	// AXI response codes
	localparam logic [1:0] KWD_RESP_OK = 2'h0;
	localparam logic [1:0] KWD_RESP_DECERR = 2'h3;

	typedef struct packed {
		logic on;
		logic rst_on_exp;
		logic rst_seen;
		logic int_seen;
		logic [3:0] rsvd;
		logic [KWD_TMO_W-1:0] tmo;
	} kwd_ctrl_t;

	typedef enum logic [2:0] {
		KEY_IDLE,
		KEY_CFG1,
		KEY_CFG_ARMED,
		KEY_RD1,
		KEY_RD_ARMED
	} kwd_key_t;

endpackage

// ===== src/kwd_watchdog.sv
// Operation
// - Watchdog counts from reset without software action
// - One unlock per configuration write; others ignored
// - Control reads only after 5555h then AAAAh
// - Bit 15 enables counting and timeout action
// - Bit 14 set: timeout asserts system reset
// - Bit 14 clear: interrupt first, then reset
// - Bit 13 marks watchdog reset, cleared by keys
// - Bit 12 marks interrupt issued, cleared by keys
// - Bits 7 to 0 choose power-of-two interval
// - Lowest set bit picks exponent 10, 20..26
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module kwd_watchdog import kwd_pkg::*; #(
	parameter int EXP_LO = KWD_EXP_LO,
	parameter int EXP_HI = KWD_EXP_HI
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [KWD_AW-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [KWD_AW-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic wdg_nmi,
	output logic wdg_sys_reset
);

	// Exponent from lowest set bit of the timeout field; zero field means no timeout
	function automatic logic [4:0] kwd_exp(input logic [KWD_TMO_W-1:0] f);
		logic [4:0] e;
		e = 5'h00;
		for (int i = KWD_TMO_W - 1; i >= 0; i--) begin
			if (f[i]) begin
				e = (i == 0) ? 5'(EXP_LO) : 5'(EXP_HI + i - 1);
			end
		end
		return e;
	endfunction

	// Control register decode, shared by the write and read paths
	function automatic logic is_ctrl(input logic [KWD_AW-1:0] a);
		return a == KWD_CTRL_ADDR;
	endfunction

	kwd_ctrl_t ctrl_r;
	kwd_key_t key_r;
	logic [KWD_CNT_W-1:0] cnt_r;
	logic [KWD_CNT_W-1:0] term;
	logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic aw_full_r, w_full_r, ar_full_r;
	logic [KWD_AW-1:0] aw_addr_r, ar_addr_r;
	logic [15:0] wdata_r;
	logic [1:0] wstrb_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r;
	logic nmi_r, sysrst_r;
	logic wr_go, wr_hit, rd_go, rd_hit, cfg_wr, expiry, timing;

	// Bus handshakes, outputs straight from flops
	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;
	assign wdg_nmi = nmi_r;
	assign wdg_sys_reset = sysrst_r;

	// Write executes once address and data are both held
	assign wr_go = aw_full_r && w_full_r && !bvalid_r;
	assign wr_hit = wr_go && is_ctrl(aw_addr_r) && (wstrb_r == 2'h3);
	// Reads yield to a write in the same cycle so the key state has one mover
	assign rd_go = ar_full_r && !rvalid_r && !wr_go;
	assign rd_hit = rd_go && is_ctrl(ar_addr_r);
	assign cfg_wr = wr_hit && (key_r == KEY_CFG_ARMED);

	// Write address and data channels, taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			aw_addr_r <= '0;
			wdata_r <= 16'h0000;
			wstrb_r <= 2'h0;
		end else begin
			if (s_axi_awvalid && awready_r) begin
				aw_addr_r <= s_axi_awaddr;
				aw_full_r <= 1'b1;
				awready_r <= 1'b0;
			end
			if (s_axi_wvalid && wready_r) begin
				wdata_r <= s_axi_wdata[15:0];
				wstrb_r <= s_axi_wstrb[1:0];
				w_full_r <= 1'b1;
				wready_r <= 1'b0;
			end
			if (wr_go) begin
				aw_full_r <= 1'b0;
				w_full_r <= 1'b0;
			end
			if (bvalid_r && s_axi_bready) begin
				awready_r <= 1'b1;
				wready_r <= 1'b1;
			end
		end
	end

	// Write response, one cycle after the pair is complete
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r <= KWD_RESP_OK;
		end else if (wr_go) begin
			bvalid_r <= 1'b1;
			bresp_r <= is_ctrl(aw_addr_r) ? KWD_RESP_OK : KWD_RESP_DECERR;
		end else if (bvalid_r && s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// Read channel; control contents only while the read key is armed
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b1;
			ar_full_r <= 1'b0;
			ar_addr_r <= '0;
			rvalid_r <= 1'b0;
			rresp_r <= KWD_RESP_OK;
			rdata_r <= 32'h00000000;
		end else begin
			if (s_axi_arvalid && arready_r) begin
				ar_addr_r <= s_axi_araddr;
				ar_full_r <= 1'b1;
				arready_r <= 1'b0;
			end
			if (rd_go) begin
				ar_full_r <= 1'b0;
				rvalid_r <= 1'b1;
				rresp_r <= is_ctrl(ar_addr_r) ? KWD_RESP_OK : KWD_RESP_DECERR;
				if (rd_hit && key_r == KEY_RD_ARMED) begin
					rdata_r <= {16'h0000, ctrl_r.on, ctrl_r.rst_on_exp, ctrl_r.rst_seen,
						ctrl_r.int_seen, 4'h0, ctrl_r.tmo};
				end else begin
					rdata_r <= 32'h00000000;
				end
			end else if (rvalid_r && s_axi_rready) begin
				rvalid_r <= 1'b0;
				arready_r <= 1'b1;
			end
		end
	end

	// Key sequencer; a stray value anywhere drops back to idle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			key_r <= KEY_IDLE;
		end else if (wr_hit) begin
			unique case (key_r)
				KEY_CFG_ARMED: key_r <= KEY_IDLE;
				KEY_CFG1: key_r <= (wdata_r == KWD_KEY_CFG2) ? KEY_CFG_ARMED :
					(wdata_r == KWD_KEY_CFG1) ? KEY_CFG1 :
					(wdata_r == KWD_KEY_RD1) ? KEY_RD1 : KEY_IDLE;
				KEY_RD1: key_r <= (wdata_r == KWD_KEY_RD2) ? KEY_RD_ARMED :
					(wdata_r == KWD_KEY_CFG1) ? KEY_CFG1 :
					(wdata_r == KWD_KEY_RD1) ? KEY_RD1 : KEY_IDLE;
				KEY_IDLE, KEY_RD_ARMED: key_r <= (wdata_r == KWD_KEY_CFG1) ? KEY_CFG1 :
					(wdata_r == KWD_KEY_RD1) ? KEY_RD1 : KEY_IDLE;
			endcase
		end else if (rd_hit && key_r == KEY_RD_ARMED) begin
			key_r <= KEY_IDLE; // One read per unlock
		end
	end

	// Interval terminal count; zero field leaves the counter parked
	assign timing = ctrl_r.on && (ctrl_r.tmo != '0);
	assign term = KWD_CNT_W'((28'h0000001 << kwd_exp(ctrl_r.tmo)) - 28'h0000001);
	assign expiry = timing && (cnt_r == term);

	// Free-running count, live straight out of reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= '0;
		end else if (cfg_wr || expiry) begin
			cnt_r <= '0;
		end else if (timing) begin
			cnt_r <= cnt_r + KWD_CNT_W'(1);
		end
	end

	// Expiry action pulses; interrupt only once before escalating
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			nmi_r <= 1'b0;
			sysrst_r <= 1'b0;
		end else begin
			nmi_r <= expiry && !ctrl_r.rst_on_exp && !ctrl_r.int_seen;
			sysrst_r <= expiry && (ctrl_r.rst_on_exp || ctrl_r.int_seen);
		end
	end

	// Control word; flags set by expiry win over the keyed clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= kwd_ctrl_t'(KWD_CTRL_RST);
		end else begin
			if (cfg_wr) begin
				ctrl_r.on <= wdata_r[KWD_ON_BIT];
				ctrl_r.rst_on_exp <= wdata_r[KWD_RSTON_BIT];
				ctrl_r.tmo <= wdata_r[KWD_TMO_LSB +: KWD_TMO_W];
				ctrl_r.rst_seen <= 1'b0;
				ctrl_r.int_seen <= 1'b0;
			end
			ctrl_r.rsvd <= 4'h0;
			// Flags survive the watchdog reset, which does not touch this logic
			if (expiry && (ctrl_r.rst_on_exp || ctrl_r.int_seen)) begin
				ctrl_r.rst_seen <= 1'b1;
			end
			if (expiry && !ctrl_r.rst_on_exp && !ctrl_r.int_seen) begin
				ctrl_r.int_seen <= 1'b1;
			end
		end
	end

	// Checks next to the logic
	// Sampled reset in the antecedent: the release edge still sees the held count
	count_runs_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(aresetn && timing && !expiry && !cfg_wr) |=> cnt_r == $past(cnt_r) + KWD_CNT_W'(1))
		else $error("count did not advance");

	cfg_locked_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_hit && key_r != KEY_CFG_ARMED) |=> ctrl_r.tmo == $past(ctrl_r.tmo)
		&& ctrl_r.on == $past(ctrl_r.on))
		else $error("config changed without unlock");

	read_locked_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(rd_go && key_r != KEY_RD_ARMED) |=> rvalid_r && rdata_r == 32'h00000000)
		else $error("control read without unlock");

	off_holds_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(!ctrl_r.on && !cfg_wr) |=> $stable(cnt_r) && !nmi_r && !sysrst_r)
		else $error("disabled watchdog moved");

	reset_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(expiry && ctrl_r.rst_on_exp) |=> sysrst_r && !nmi_r && ctrl_r.rst_seen)
		else $error("reset mode did not reset");

	nmi_first_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(expiry && !ctrl_r.rst_on_exp) |=> (nmi_r != $past(ctrl_r.int_seen))
		&& (sysrst_r == $past(ctrl_r.int_seen)))
		else $error("interrupt escalation wrong");

	rst_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(sysrst_r) |-> ctrl_r.rst_seen)
		else $error("reset flag not set");

	int_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
		nmi_r |-> ctrl_r.int_seen)
		else $error("interrupt flag not set");

	rsvd_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
		rvalid_r |-> rdata_r[11:8] == 4'h0)
		else $error("reserved bits nonzero");

	exp_term_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(timing && ctrl_r.tmo[0]) |-> term == KWD_CNT_W'((28'h0000001 << EXP_LO) - 28'h0000001))
		else $error("bit 0 exponent wrong");

	key_drop_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_hit && key_r == KEY_CFG1 && wdata_r != KWD_KEY_CFG2 && wdata_r != KWD_KEY_CFG1
		&& wdata_r != KWD_KEY_RD1) |=> key_r == KEY_IDLE)
		else $error("partial key not dropped");

	cfg_restart_a: assert property (@(posedge aclk) disable iff (!aresetn)
		cfg_wr |=> cnt_r == '0 ##1 (cnt_r == '0 || cnt_r == KWD_CNT_W'(1)))
		else $error("config write did not restart count");

	one_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(nmi_r || sysrst_r) |-> cnt_r == '0 ##1 (!nmi_r && !sysrst_r))
		else $error("expiry pulse too long");

endmodule // kwd_watchdog

// ===== tb/kwd_watchdog_tb.sv
`timescale 1ns/1ps
// One comparison, counted; four-state match so an unknown never passes
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_total++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module kwd_watchdog_tb import kwd_pkg::*; ;
	// Short exponents keep the longest interval at 2^11 cycles
	localparam int LO = 3;
	localparam int HI = 5;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [KWD_AW-1:0] awaddr = '0;
	logic [KWD_AW-1:0] araddr = '0;
	logic [31:0] wdata = '0;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, nmi, srst;
	logic [1:0] bresp, rresp, resp;
	logic [31:0] rdata, rd;
	logic [7:0] f;
	int err_total = 0;
	int comparisons = 0;
	int seed = 67002;
	int n;

	always #5 aclk = ~aclk;

	kwd_watchdog #(.EXP_LO(LO), .EXP_HI(HI)) u_kwd_watchdog (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .wdg_nmi(nmi), .wdg_sys_reset(srst)
	);

	// Expected interval: lowest set field bit picks the exponent
	function automatic int period(input logic [7:0] fld);
		for (int k = 0; k < 8; k++) begin
			if (fld[k]) return 1 << ((k == 0) ? LO : HI + k - 1);
		end
		return 0;
	endfunction

	// Write: address and data offered together, each dropped when taken
	// No cycle limit of its own; a stuck slave is left to the watchdog
	task automatic wr(input logic [KWD_AW-1:0] a, input logic [15:0] d);
		bit done;
		done = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {16'h0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				resp = bresp;
				bready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask

	// Read: data and response taken at the edge where rvalid is seen
	task automatic rdr(input logic [KWD_AW-1:0] a, output logic [31:0] d);
		bit done;
		done = 1'b0;
		d = 'x;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata;
				resp = rresp;
				rready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask

	task automatic key_rd(output logic [31:0] d);
		wr(KWD_CTRL_ADDR, KWD_KEY_RD1);
		wr(KWD_CTRL_ADDR, KWD_KEY_RD2);
		rdr(KWD_CTRL_ADDR, d);
	endtask

	// Keyed configuration; the keyed write itself restarts the count
	task automatic cfg(input logic [15:0] d);
		wr(KWD_CTRL_ADDR, KWD_KEY_CFG1);
		wr(KWD_CTRL_ADDR, KWD_KEY_CFG2);
		wr(KWD_CTRL_ADDR, d);
	endtask

	// Edges until the next expiry pulse, capped so a silent timer cannot hang
	task automatic gap(input int lim);
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (!(nmi || srst) && n < lim);
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Guards against a stuck handshake or a timer that never fires
	// About 13k cycles of tests; 30k leaves ample margin
	initial begin
		#300000;
		err_total++;
		final_report;
	end

	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		gap(3000);
		`CHK(nmi, 1'b1)
		`CHK(n <= 2049, 1'b1)
		$display("test power_on done");
		rdr(KWD_CTRL_ADDR, rd);
		`CHK(rd, 32'h0)
		wr(12'h000, 16'h1234);
		`CHK(resp, KWD_RESP_DECERR)
		rdr(12'h004, rd);
		`CHK(resp, KWD_RESP_DECERR)
		// Unkeyed write, then a sequence broken by a stray value
		wr(KWD_CTRL_ADDR, 16'h0001);
		wr(KWD_CTRL_ADDR, KWD_KEY_CFG1);
		wr(KWD_CTRL_ADDR, 16'h1234);
		wr(KWD_CTRL_ADDR, KWD_KEY_CFG2);
		wr(KWD_CTRL_ADDR, 16'h0001);
		// Single-byte strobe: the key is not counted, so the sequence never arms
		wstrb <= 4'h1;
		wr(KWD_CTRL_ADDR, KWD_KEY_CFG1);
		`CHK(resp, KWD_RESP_OK)
		wstrb <= 4'hF;
		wr(KWD_CTRL_ADDR, KWD_KEY_CFG2);
		wr(KWD_CTRL_ADDR, 16'h0001);
		key_rd(rd);
		`CHK(rd, 32'h9080)
		`CHK(resp, KWD_RESP_OK)
		rdr(KWD_CTRL_ADDR, rd);
		`CHK(rd, 32'h0)
		$display("test keys done");
		cfg(16'h8001);
		gap(20);
		`CHK(n <= 8, 1'b1)
		`CHK(nmi, 1'b1)
		gap(20);
		`CHK(n, 8)
		`CHK(srst, 1'b1)
		key_rd(rd);
		`CHK(rd, 32'hB001)
		$display("test interrupt_mode done");
		// Every exponent bit in reset mode, random bits above it, reserved bits set
		for (int k = 0; k < 8; k++) begin
			f = 8'($random(seed) << k) | (8'h01 << k);
			cfg({8'hCF, f});
			gap(5000);
			gap(5000);
			`CHK(n, period(f))
			`CHK(srst, 1'b1)
			key_rd(rd);
			`CHK(rd, {16'h0000, 8'hE0, f})
		end
		$display("test reset_mode done");
		// External reset mid-run: flags drop, default word returns, count restarts
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		key_rd(rd);
		`CHK(rd, {16'h0000, KWD_CTRL_RST})
		gap(3000);
		`CHK(nmi, 1'b1)
		$display("test reset_again done");
		cfg(16'h0001);
		gap(200);
		`CHK(n, 200)
		key_rd(rd);
		`CHK(rd, 32'h0001)
		$display("test disabled done");
		final_report;
	end
endmodule // kwd_watchdog_tb
